// >>> logic/fcs_pkg.sv
// Package of constants and types for the configuration state sequencer
package fcs_pkg;

   // ==============================================
   // Timing counts in cycles of the 50 MHz clock; the two periods in ns
   // ==============================================
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int INIT_HIGH_CYCLES = 2;
   localparam int MASTER_EXTRA_CYCLES = 6;
   localparam int POWERUP_CYCLES = 8;
   localparam int CLEAR_CYCLES = 16;
   localparam int CFGCLK_PERIOD_NS = 160;
   localparam int CFGCLK_HALF_CYCLES = CFGCLK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);

   // ==============================================
   // Field positions, widths and reset values
   // ==============================================
   localparam int LENGTH_WIDTH = 24;
   localparam int MODE_WIDTH = 4;
   localparam int MODE_MASTER_BIT = 0;
   localparam int DELAY_WIDTH = 3;
   localparam logic [2:0] DELAY_MAX = 3'h4;
   localparam logic [2:0] DONE_EDGE_RESET = 3'h1;
   localparam logic [3:0] EDGE_CNT_MAX = 4'hf;

   // ==============================================
   // Start-up modes and sequencer states
   // ==============================================
   typedef enum logic [1:0] {
      cfgclk_synced_startup = 2'h0,
      cfgclk_free_startup = 2'h1,
      userclk_synced_startup = 2'h2,
      userclk_free_startup = 2'h3
   } fcs_startup_type;

   typedef enum {
      ST_POWERUP,
      ST_CLEAR,
      ST_INIT_HOLD,
      ST_INIT_SETTLE,
      ST_MASTER_EXTEND,
      ST_CONFIG,
      ST_STARTUP,
      ST_OPERATE
   } fcs_state_type;

endpackage

// >>> logic/fcs_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module fcs_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_q;

   // ==============================================
   // Two stages, the first read only by the second
   // ==============================================
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stage1_q <= RESET_VALUE;
         syncOut <= RESET_VALUE;
      end else begin
         stage1_q <= asyncIn;
         syncOut <= stage1_q;
      end
   end
endmodule
`default_nettype wire

// >>> logic/fcs_sequencer.sv
// Configuration state sequencer: initialization, configuration, start-up
// How it works
// - Setup-ready and completion pins low during initialization
// - Clear configuration memory; option skips on reconfiguration
// - Release setup-ready; wait while wire held low
// - Two cycles high, sample mode, then configure
// - Drive configuring indicator outputs in init and configuration
// - Reset or reprogram aborts configuration; deassert to restart
// - After configuration only reprogram restarts loading
// - Master sources clock, waits six extra cycles
// - Count clocks; finish on length match and end frame
// - Unused I/O high-impedance with pull-up while configuring
// - Hold flip-flops set/reset, disable internal bidirectional buffers
// - Three start-up events timed independently
// - Four start-up modes; user clock modes
// - Synced modes wait completion pin; free modes count edges
// - Open-drain completion pin, pull-up, sensed internally
// - Default mode releases completion on first start-up edge
// - In synced modes, completion held low withholds release and activation
// - Each event zero to four edges after completion in synced modes, after start-up begins in free modes; completion release one to four
// - Release completion before I/O activation is advised
// - Reprogram pulse clears, resamples mode, reconfigures
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer
   import fcs_pkg::*;
#(
   parameter int POWERUP_COUNT = POWERUP_CYCLES,
   parameter int CLEAR_COUNT = CLEAR_CYCLES,
   parameter int CFGCLK_HALF = CFGCLK_HALF_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic reprogram_n,
   input wire logic resetPinN,
   input wire logic setupReadyIn,
   input wire logic doneIn,
   input wire logic config_clock,
   input wire logic user_startup_clock,
   input wire logic [MODE_WIDTH-1:0] modePins,
   input wire logic [LENGTH_WIDTH-1:0] loadedLength,
   input wire logic endFrameWritten,
   input wire logic keepMemoryOnReconfig,
   input wire logic [1:0] startupMode,
   input wire logic [DELAY_WIDTH-1:0] doneEdgeSel,
   input wire logic [DELAY_WIDTH-1:0] ffDelaySel,
   input wire logic [DELAY_WIDTH-1:0] ioDelaySel,
   input wire logic donePullupCfg,
   output logic setupReadyOut,
   output logic setupReadyOe,
   output logic doneOut,
   output logic doneOe,
   output logic donePullupEn,
   output logic high_while_configuring,
   output logic low_while_configuring,
   output logic cfgIndicatorOe,
   output logic memClear,
   output logic [MODE_WIDTH-1:0] sampledMode,
   output logic config_clockOut,
   output logic config_clockOe,
   output logic [LENGTH_WIDTH-1:0] configCount,
   output logic unusedIoHighZ,
   output logic unusedIoPullup,
   output logic logic_cellSetReset,
   output logic internal_bidir_bufferOff,
   output logic edge_tristate_bufferOn,
   output logic operating
);
   initial begin
      if (POWERUP_COUNT < 1 || CLEAR_COUNT < 1 || CFGCLK_HALF < 1)
         $error("fcs_sequencer: counts must be at least one");
   end

   // ==============================================
   // Decoding functions
   // ==============================================
   function automatic logic isMaster(input logic [MODE_WIDTH-1:0] m);
      isMaster = !m[MODE_MASTER_BIT];
   endfunction

   function automatic logic [3:0] clampDelay(input logic [2:0] d);
      clampDelay = (d > DELAY_MAX) ? {1'b0, DELAY_MAX} : {1'b0, d};
   endfunction

   // ==============================================
   // Input synchronisers
   // ==============================================
   logic [9:0] syncBus;
   logic reprogSync, resetSync, initSync, doneSync, cclkSync, uclkSync;
   logic [MODE_WIDTH-1:0] modeSync;

   fcs_sync #(.WIDTH(10), .RESET_VALUE(10'h00f)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .asyncIn({modePins, user_startup_clock, config_clock, doneIn,
         setupReadyIn, resetPinN, reprogram_n}),
      .syncOut(syncBus)
   );

   assign reprogSync = syncBus[0];
   assign resetSync = syncBus[1];
   assign initSync = syncBus[2];
   assign doneSync = syncBus[3]; // Sensed wire level
   assign cclkSync = syncBus[4];
   assign uclkSync = syncBus[5];
   assign modeSync = syncBus[9:6];

   // ==============================================
   // State and counters
   // ==============================================
   fcs_state_type state_q, state_d;
   logic [7:0] waitCnt_q, waitCnt_d;
   logic [LENGTH_WIDTH-1:0] cfgCnt_q, cfgCnt_d;
   logic [3:0] startCnt_q, startCnt_d, postCnt_q, postCnt_d;
   logic [7:0] divCnt_q;
   logic genClk_q, cclkPrev_q, uclkPrev_q, configuredOnce_q;
   logic doneRel_q, doneRel_d, doneSeen_q, doneSeen_d;
   logic ffRel_q, ffRel_d, ioAct_q, ioAct_d;
   logic [MODE_WIDTH-1:0] mode_q, mode_d;

   // ==============================================
   // Edge detection and clock selection
   // ==============================================
   logic masterMode, genRise, extRise, userRise, cfgEdge, suEdge;
   logic userClkMode, syncedMode, skipClear, abortReq, clockSourcing;
   logic [3:0] doneEdgeNum, ffDelay, ioDelay;
   assign masterMode = isMaster(mode_q);
   assign genRise = (divCnt_q == 8'(CFGCLK_HALF - 1)) && !genClk_q;
   assign extRise = cclkSync && !cclkPrev_q;
   assign userRise = uclkSync && !uclkPrev_q;
   assign cfgEdge = masterMode ? genRise : extRise;
   // User clock modes time start-up from the user clock
   assign userClkMode = startupMode[1];
   assign syncedMode = !startupMode[0];
   assign suEdge = userClkMode ? userRise : cfgEdge;
   assign doneEdgeNum = (doneEdgeSel == 3'h0) ? 4'h1 : clampDelay(doneEdgeSel);
   assign ffDelay = clampDelay(ffDelaySel);
   assign ioDelay = clampDelay(ioDelaySel);
   assign skipClear = keepMemoryOnReconfig && configuredOnce_q;
   assign abortReq = !resetSync || !reprogSync;
   // Master sources the configuration clock while loading and during start-up
   assign clockSourcing = masterMode &&
      (state_q == ST_CONFIG || state_q == ST_STARTUP);

   // Configuration clock divider
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         divCnt_q <= 8'h00;
         genClk_q <= 1'b0;
      end else if (divCnt_q == 8'(CFGCLK_HALF - 1)) begin
         divCnt_q <= 8'h00;
         genClk_q <= !genClk_q;
      end else begin
         divCnt_q <= divCnt_q + 8'h01;
      end
   end

   // Previous sampled clock levels
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cclkPrev_q <= 1'b0;
         uclkPrev_q <= 1'b0;
      end else begin
         cclkPrev_q <= cclkSync;
         uclkPrev_q <= uclkSync;
      end
   end

   // ==============================================
   // Next-state logic
   // ==============================================
   always_comb begin
      state_d = state_q;
      waitCnt_d = waitCnt_q;
      cfgCnt_d = cfgCnt_q;
      startCnt_d = startCnt_q;
      postCnt_d = postCnt_q;
      doneRel_d = doneRel_q;
      doneSeen_d = doneSeen_q;
      ffRel_d = ffRel_q;
      ioAct_d = ioAct_q;
      mode_d = mode_q;
      case (state_q)
         ST_POWERUP: begin
            waitCnt_d = waitCnt_q + 8'h01;
            if (waitCnt_q == 8'(POWERUP_COUNT - 1)) begin
               state_d = ST_CLEAR;
               waitCnt_d = 8'h00;
            end
         end
         ST_CLEAR: begin
            waitCnt_d = waitCnt_q + 8'h01;
            if (skipClear || waitCnt_q == 8'(CLEAR_COUNT - 1)) begin
               state_d = ST_INIT_HOLD;
               waitCnt_d = 8'h00;
            end
         end
         ST_INIT_HOLD: begin
            // Wire-ANDed pin and both restart inputs must be high
            if (initSync && !abortReq) begin
               state_d = ST_INIT_SETTLE;
               waitCnt_d = 8'h01;
            end
         end
         ST_INIT_SETTLE: begin
            waitCnt_d = waitCnt_q + 8'h01;
            if (!initSync || abortReq) begin
               state_d = ST_INIT_HOLD;
               waitCnt_d = 8'h00;
            end else if (waitCnt_q == 8'(INIT_HIGH_CYCLES)) begin
               mode_d = modeSync;
               waitCnt_d = 8'h01;
               cfgCnt_d = '0;
               state_d = isMaster(modeSync) ? ST_MASTER_EXTEND : ST_CONFIG;
            end
         end
         ST_MASTER_EXTEND: begin
            waitCnt_d = waitCnt_q + 8'h01;
            if (waitCnt_q == 8'(MASTER_EXTRA_CYCLES)) begin
               state_d = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            if (abortReq) begin
               state_d = ST_CLEAR;
               waitCnt_d = 8'h00;
            end else if (cfgCnt_q == loadedLength && endFrameWritten) begin
               state_d = ST_STARTUP;
               startCnt_d = 4'h0;
               postCnt_d = 4'h0;
               doneRel_d = 1'b0;
               doneSeen_d = 1'b0;
               ffRel_d = 1'b0;
               ioAct_d = 1'b0;
            end else if (cfgEdge) begin
               cfgCnt_d = cfgCnt_q + 24'h000001;
            end
         end
         ST_STARTUP: begin
            if (!reprogSync) begin
               state_d = ST_CLEAR;
               waitCnt_d = 8'h00;
            end else begin
               if (suEdge && startCnt_q != EDGE_CNT_MAX)
                  startCnt_d = startCnt_q + 4'h1;
               // Completion released on its own edge number
               if (startCnt_d >= doneEdgeNum)
                  doneRel_d = 1'b1;
               if (doneRel_q && doneSync)
                  doneSeen_d = 1'b1;
               if (doneSeen_q && suEdge && postCnt_q != EDGE_CNT_MAX)
                  postCnt_d = postCnt_q + 4'h1;
               // Synced events wait for the sensed pin
               if (syncedMode ? (doneSeen_d && postCnt_d >= ffDelay) :
                     (startCnt_d >= ffDelay))
                  ffRel_d = 1'b1;
               if (syncedMode ? (doneSeen_d && postCnt_d >= ioDelay) :
                     (startCnt_d >= ioDelay))
                  ioAct_d = 1'b1;
               if (doneRel_q && ffRel_q && ioAct_q)
                  state_d = ST_OPERATE;
            end
         end
         ST_OPERATE: begin
            if (!reprogSync) begin
               state_d = ST_CLEAR;
               waitCnt_d = 8'h00;
            end
         end
         default: begin
            state_d = ST_POWERUP;
            waitCnt_d = 8'h00;
         end
      endcase
   end

   // ==============================================
   // Output decoding from the next state
   // ==============================================
   logic inInit_d, inCfg_d, loading_d, doneDrive_d, ioOff_d, ffHold_d;
   assign inInit_d = (state_d == ST_POWERUP) || (state_d == ST_CLEAR);
   assign loading_d = (state_d != ST_STARTUP) && (state_d != ST_OPERATE);
   assign inCfg_d = loading_d;
   assign doneDrive_d = loading_d || (state_d == ST_STARTUP && !doneRel_d);
   assign ioOff_d = loading_d || (state_d == ST_STARTUP && !ioAct_d);
   assign ffHold_d = loading_d || (state_d == ST_STARTUP && !ffRel_d);

   // Sequencer registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_POWERUP;
         waitCnt_q <= 8'h00;
         cfgCnt_q <= '0;
         startCnt_q <= 4'h0;
         postCnt_q <= 4'h0;
         doneRel_q <= 1'b0;
         doneSeen_q <= 1'b0;
         ffRel_q <= 1'b0;
         ioAct_q <= 1'b0;
         mode_q <= '0;
      end else begin
         state_q <= state_d;
         waitCnt_q <= waitCnt_d;
         cfgCnt_q <= cfgCnt_d;
         startCnt_q <= startCnt_d;
         postCnt_q <= postCnt_d;
         doneRel_q <= doneRel_d;
         doneSeen_q <= doneSeen_d;
         ffRel_q <= ffRel_d;
         ioAct_q <= ioAct_d;
         mode_q <= mode_d;
      end
   end

   // Remembers that one configuration has completed
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         configuredOnce_q <= 1'b0;
      else if (state_q == ST_OPERATE)
         configuredOnce_q <= 1'b1;
   end

   // Registered pin and control outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         setupReadyOut <= 1'b0;
         setupReadyOe <= 1'b1;
         doneOut <= 1'b0;
         doneOe <= 1'b1;
         donePullupEn <= 1'b1;
         high_while_configuring <= 1'b1;
         low_while_configuring <= 1'b0;
         cfgIndicatorOe <= 1'b1;
         memClear <= 1'b0;
         sampledMode <= '0;
         config_clockOut <= 1'b0;
         config_clockOe <= 1'b0;
         configCount <= '0;
         unusedIoHighZ <= 1'b1;
         unusedIoPullup <= 1'b1;
         logic_cellSetReset <= 1'b1;
         internal_bidir_bufferOff <= 1'b1;
         edge_tristate_bufferOn <= 1'b1;
         operating <= 1'b0;
      end else begin
         setupReadyOut <= 1'b0;
         setupReadyOe <= inInit_d;
         doneOut <= 1'b0;
         doneOe <= doneDrive_d;
         donePullupEn <= donePullupCfg;
         high_while_configuring <= inCfg_d;
         low_while_configuring <= !inCfg_d;
         cfgIndicatorOe <= inCfg_d;
         memClear <= (state_d == ST_CLEAR) && !skipClear;
         sampledMode <= mode_d;
         config_clockOut <= clockSourcing && genClk_q;
         config_clockOe <= clockSourcing;
         configCount <= cfgCnt_d;
         unusedIoHighZ <= ioOff_d;
         unusedIoPullup <= ioOff_d;
         logic_cellSetReset <= ffHold_d;
         internal_bidir_bufferOff <= ffHold_d || loading_d;
         edge_tristate_bufferOn <= 1'b1;
         operating <= (state_d == ST_OPERATE);
      end
   end

   // ==============================================
   // Assertions
   // ==============================================
   sequence s_initHighTwo;
      (state_q == ST_INIT_SETTLE) && initSync && !abortReq
         && waitCnt_q == 8'(INIT_HIGH_CYCLES);
   endsequence

   sequence s_cfgDone;
      state_q == ST_CONFIG && !abortReq && cfgCnt_q == loadedLength
         && endFrameWritten;
   endsequence

   a_init_pins_low: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_CLEAR) |-> (setupReadyOe && doneOe))
      else $error("setup-ready or completion not driven low in init");

   a_clear_skip_opt: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_CLEAR && memClear) |-> !skipClear)
      else $error("memory cleared although the skip option holds");

   a_hold_while_low: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_INIT_HOLD && !initSync) |=> state_q == ST_INIT_HOLD)
      else $error("left initialization while setup-ready low");

   a_mode_sampled: assert property (@(posedge clock) disable iff (!rstn)
      s_initHighTwo |=> (mode_q == $past(modeSync)) &&
      (state_q == ST_CONFIG || state_q == ST_MASTER_EXTEND))
      else $error("mode not sampled after two high cycles");

   a_cfg_indicators: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_CONFIG) |-> (high_while_configuring &&
      !low_while_configuring && cfgIndicatorOe))
      else $error("configuring indicators wrong");

   a_abort_restart: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_CONFIG && abortReq) |=> state_q == ST_CLEAR)
      else $error("abort did not return to initialization");

   a_reset_ignored: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_OPERATE && reprogSync) |=> state_q == ST_OPERATE)
      else $error("reconfigured without reprogram");

   a_master_extend: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_INIT_SETTLE && $past(state_q) == ST_INIT_SETTLE
      && state_d == ST_MASTER_EXTEND) |=> (state_q == ST_MASTER_EXTEND)[*6]
      ##1 state_q == ST_CONFIG)
      else $error("master extension not six cycles");

   a_length_exit: assert property (@(posedge clock) disable iff (!rstn)
      s_cfgDone |=> state_q == ST_STARTUP && configCount == $past(cfgCnt_q))
      else $error("configuration did not end on length match");

   a_io_tristated: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_CONFIG) |-> (unusedIoHighZ && unusedIoPullup &&
      logic_cellSetReset && internal_bidir_bufferOff))
      else $error("I/O or flip-flops active during configuration");

   a_sync_withhold: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_STARTUP && syncedMode && !doneSeen_q)
      |-> (logic_cellSetReset && unusedIoHighZ))
      else $error("release before completion pin seen high");

   a_done_first_edge: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == ST_STARTUP && doneEdgeNum == 4'h1 && suEdge && !reprogSync
      == 1'b0) |=> ##1 !doneOe)
      else $error("completion not released on first start-up edge");
endmodule
`default_nettype wire

// >>> tb/fcs_partner.sv
// Far-side model: wired pins with pull-ups and the source's clocks
`timescale 1ns/1ns
`default_nettype none
module fcs_partner (
   input wire logic setupReadyOe,
   input wire logic doneOe,
   input wire logic holdSetup,
   input wire logic holdDone,
   input wire logic runClock,
   output logic setupWire,
   output logic doneWire,
   output var logic slaveClock,
   output var logic userClock
);
   // Wire-AND with pull-up, low if any party pulls
   assign setupWire = !(setupReadyOe || holdSetup);
   assign doneWire = !(doneOe || holdDone);
   // Source clock runs within frames only; user clock runs free
   initial begin
      slaveClock = 1'b0;
      userClock = 1'b0;
      forever begin
         #80;
         slaveClock = runClock ? !slaveClock : 1'b0;
         userClock = !userClock;
      end
   end
endmodule
`default_nettype wire

// >>> tb/fcs_sequencer_tb.sv
// Self-checking testbench for the configuration state sequencer
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer_tb;
   import fcs_pkg::*;
   // ====================
   // Signals
   // ====================
   localparam logic [23:0] LEN = 24'h5;
   logic clock, rstn, reprogramN, resetPinN, holdSetup, holdDone, endFrame;
   logic keep, pullCfg, runClock, sawClear;
   logic [1:0] stMode;
   logic [3:0] modePins, sampledMode;
   logic [2:0] ioDelay;
   logic [23:0] configCount;
   logic setupReadyOe, doneOe, donePullupEn, hwc, lwc, memClear, ckOut, ckOe;
   logic ioHighZ, ioPullup, setReset, bidirOff, edgeOn, operating;
   wire setupWire, doneWire, slaveClock, userClock;
   int numErrors, checkCount, nS0, nM0, nS1, nM1;
   // Master sources the clock, otherwise the partner does
   wire cfgClk = ckOe ? ckOut : slaveClock;
   fcs_sequencer #(.POWERUP_COUNT(2), .CLEAR_COUNT(4),
      .CFGCLK_HALF(CFGCLK_HALF_CYCLES)) i_fcs_sequencer (.clock(clock),
      .rstn(rstn), .reprogram_n(reprogramN), .resetPinN(resetPinN),
      .setupReadyIn(setupWire), .doneIn(doneWire), .config_clock(cfgClk),
      .user_startup_clock(userClock), .modePins(modePins),
      .loadedLength(LEN), .endFrameWritten(endFrame),
      .keepMemoryOnReconfig(keep), .startupMode(stMode),
      .doneEdgeSel(3'h1), .ffDelaySel(3'h0), .ioDelaySel(ioDelay),
      .donePullupCfg(pullCfg), .setupReadyOut(), .setupReadyOe(setupReadyOe),
      .doneOut(), .doneOe(doneOe), .donePullupEn(donePullupEn),
      .high_while_configuring(hwc), .low_while_configuring(lwc),
      .cfgIndicatorOe(), .memClear(memClear), .sampledMode(sampledMode),
      .config_clockOut(ckOut), .config_clockOe(ckOe),
      .configCount(configCount), .unusedIoHighZ(ioHighZ),
      .unusedIoPullup(ioPullup), .logic_cellSetReset(setReset),
      .internal_bidir_bufferOff(bidirOff), .edge_tristate_bufferOn(edgeOn),
      .operating(operating));
   fcs_partner i_fcs_partner (.setupReadyOe(setupReadyOe), .doneOe(doneOe),
      .holdSetup(holdSetup), .holdDone(holdDone), .runClock(runClock),
      .setupWire(setupWire), .doneWire(doneWire), .slaveClock(slaveClock),
      .userClock(userClock));
   // ====================
   // Clock and helpers
   // ====================
   initial begin
      clock = 1'b0;
      forever #10 clock = !clock;
   end
   // Remember any memory clear since the last run began
   always @(posedge clock) if (memClear) sawClear <= 1'b1;
   task automatic check(input string name, input logic [23:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return setupReadyOe;
         1: return memClear;
         2: return hwc;
         3: return doneOe;
         4: return operating;
         default: return setReset;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic val);
      int n;
      n = 0;
      while (pick(sel) !== val && n < 3000) begin
         step(1);
         n++;
      end
      check("waitedSignal", 24'(pick(sel)), 24'(val));
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ====================
   // One full load and start-up in a given mode
   // ====================
   task automatic run_config(input logic [1:0] mode, input logic [3:0] mp,
      input logic kp, output int n);
      stMode = mode;
      modePins = mp;
      ioDelay = (mode == 2'h0) ? 3'h4 : 3'h0;
      keep = kp;
      holdSetup = 1'b1;
      holdDone = 1'b1;
      sawClear = 1'b0;
      if (mode != 2'h0) begin
         reprogramN = 1'b0;
         step(4);
         reprogramN = 1'b1;
      end
      wait_for(0, 1'b0);
      step(20);
      check("ckOeHeld", 24'(ckOe), 24'h0);
      check("memCleared", 24'(sawClear), 24'(!kp));
      holdSetup = 1'b0;
      n = 0;
      // Slave: configuration starts with the mode latch; master: clock drive
      while ((mp[0] ? (sampledMode !== mp) : (ckOe !== 1'b1)) && n < 100) begin
         step(1);
         n++;
      end
      step(2);
      check("ckOe", 24'(ckOe), 24'(!mp[0]));
      check("hwc", 24'(hwc), 24'h1);
      if (mode == 2'h0) begin
         resetPinN = 1'b0;
         step(4);
         resetPinN = 1'b1;
         wait_for(1, 1'b1);
      end
      runClock = 1'b1;
      wait_for(2, 1'b0);
      check("configCount", configCount, LEN);
      check("lwc", 24'(lwc), 24'h1);
      wait_for(3, 1'b0);
      step(40);
      check("ffHeld", 24'(setReset), 24'(!mode[0]));
      holdDone = 1'b0;
      wait_for(5, 1'b0);
      check("ioLate", 24'(ioHighZ), 24'(mode == 2'h0));
      wait_for(4, 1'b1);
      runClock = 1'b0;
      check("bidirOff", 24'({bidirOff, edgeOn}), 24'h1);
      check("ioActive", 24'({ioHighZ, ioPullup}), 24'h0);
      resetPinN = 1'b0;
      step(6);
      check("operating", 24'({operating, memClear}), 24'h2);
      resetPinN = 1'b1;
      $display("test startup mode %0d done", mode);
   endtask
   // ====================
   // Main sequence and watchdog
   // ====================
   initial begin
      {rstn, reprogramN, resetPinN, holdSetup, holdDone} = 5'h0f;
      // Source clock idle until a frame is sent; pull-up requested
      {endFrame, keep, pullCfg, runClock, sawClear} = 5'h14;
      {stMode, modePins, ioDelay} = 9'h001;
      repeat (4) @(posedge clock);
      #2;
      check("resetOut", 24'({setupReadyOe, doneOe, hwc, lwc, setReset, ioHighZ,
         ioPullup, edgeOn, donePullupEn, bidirOff, operating}),
         24'h77e);
      rstn = 1'b1;
      run_config(2'h0, 4'h1, 1'b0, nS0);
      run_config(2'h1, 4'h0, 1'b0, nM0);
      // Six extra cycles, plus the clock-enable output register
      check("masterExtra", 24'(nM0 - nS0),
         24'(MASTER_EXTRA_CYCLES + 1));
      run_config(2'h2, 4'h3, 1'b0, nS1);
      check("pullupOn", 24'(donePullupEn), 24'h1);
      pullCfg = 1'b0;
      run_config(2'h3, 4'h2, 1'b1, nM1);
      check("masterExtra", 24'(nM1 - nS1),
         24'(MASTER_EXTRA_CYCLES + 1));
      check("pullup", 24'(donePullupEn), 24'h0);
      stop_test;
   end
   initial begin
      #500000;
      numErrors++;
      stop_test;
   end
endmodule
`default_nettype wire
